//--- core/ssfng_consts.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 40 MHz pclk; included by the package and the supervisor core
`ifndef SSFNG_CONSTS_SVH
`define SSFNG_CONSTS_SVH

`define SSFNG_CLK_NS          25
`define SSFNG_SYNC_LOW_NS     500
`define SSFNG_TB_PERIOD_NS    10000
`define SSFNG_TB_LOW_NS       1000
`define SSFNG_US_NS           1000
// Least times round up
`define SSFNG_SYNC_LOW_CYC    ((`SSFNG_SYNC_LOW_NS + `SSFNG_CLK_NS - 1) / `SSFNG_CLK_NS)
`define SSFNG_TB_PERIOD_CYC   ((`SSFNG_TB_PERIOD_NS + `SSFNG_CLK_NS - 1) / `SSFNG_CLK_NS)
`define SSFNG_TB_LOW_CYC      ((`SSFNG_TB_LOW_NS + `SSFNG_CLK_NS - 1) / `SSFNG_CLK_NS)
`define SSFNG_US_CYC          ((`SSFNG_US_NS + `SSFNG_CLK_NS - 1) / `SSFNG_CLK_NS)

`define SSFNG_OFF_CTRL        12'h000
`define SSFNG_OFF_STATUS      12'h004
`define SSFNG_OFF_FLT_RESP    12'h008
`define SSFNG_OFF_PIN_CFG     12'h00C
`define SSFNG_OFF_RETRY       12'h010
`define SSFNG_OFF_IRQ_STS     12'h014
`define SSFNG_OFF_IRQ_CLR     12'h018
`define SSFNG_OFF_IRQ_EN      12'h01C
`define SSFNG_OFF_LOG         12'h020
`define SSFNG_OFF_PEAK        12'h024
`define SSFNG_OFF_ADDR        12'h028

`define SSFNG_CTRL_LOG_EN     0
`define SSFNG_CTRL_RESTART    1
`define SSFNG_CTRL_SYNC_EN    2
`define SSFNG_STS_NVM_INIT    3
`define SSFNG_RST_ADDR        7'h40
`define SSFNG_RST_RETRY       16'h0064
`define SSFNG_RST_FLT_RESP    14'h0000
`define SSFNG_GLOBAL_A        7'h5A
`define SSFNG_GLOBAL_B        7'h5B
`define SSFNG_UNLOCK_CMD      8'hBD
`define SSFNG_UNLOCK_D1       8'h2B
`define SSFNG_UNLOCK_D2       8'hC4

`endif

//--- core/ssfng_core.sv
// Supervisor: supply lockout, start/stop sequencing, memory unlock, fault response, timebase pins
// Assumes APB master on pclk, bus-target writes and fault events on pclk, comparators asynchronous
//
// Overview of operation
// R1 - Initialise only when input near 4V and internal supplies within 20%.
// R2 - Hold run lines and timebase line low until 3.3V supply within 7%.
// R3 - Sequencing starts only after input exceeds start threshold.
// R4 - Below stop threshold pull timebase low; restart only above start threshold.
// R5 - Logic-only supply runs digital part; bus stays usable, power stage off.
// R6 - Status bit 3 reads low while input supply never applied.
// R7 - While memory uninitialised answer only addresses 5A and 5B.
// R8 - Writes BD/2B then BD/C4 to 5B unlock the configured address.
// R9 - Host saves configuration to memory after unlocking and configuring.
// R10 - After input arrives following logic-only setup, PWM and ADC wait for restart.
// R11 - Fault pins signal selected fault kinds; external low is a system fault.
// R12 - Each fault responds by ignore, latch off or retry after interval.
// R13 - Overvoltage at once forces top gate off and bottom gate on.
// R14 - With logging enabled store log at fault shutdown; peak always readable.
// R15 - Above 130C disable memory access; re-enable below 120C.
// R16 - Host avoids memory writes above 85C; RAM kept until 3.3V lockout.
// R17 - Sync output pulse held low 500ns.
// R18 - Timebase line period 10us, low 1us each period.
// R19 - Unlock writes must be back to back; other write restarts detection.
`timescale 1ns/10ps
`include "ssfng_consts.svh"
module ssfng_core
	import ssfng_pkg::*;
#(
	parameter int CHANNELS   = 2,
	parameter int SYNC_PER   = 80
) (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           clk_en,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [11:0]                    paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire ssfng_sup_type                  supplies,
	input  wire ssfng_pmb_wr_type               pmb_wr,
	input  wire logic [6:0]                     pmb_addr,
	output logic                                pmb_addr_match,
	input  wire logic [CHANNELS-1:0][5:0]       fault_evt,
	input  wire logic                           meas_valid,
	input  wire logic [15:0]                    meas_value,
	input  wire logic [CHANNELS-1:0]            fault_signal_pin_in,
	output logic      [CHANNELS-1:0]            fault_signal_pin_out,
	output logic      [CHANNELS-1:0]            fault_signal_pin_oe,
	input  wire logic                           share_clk_in,
	output logic                                share_clk_out,
	output logic                                share_clk_oe,
	output logic                                sync_out,
	output logic                                sync_oe,
	output logic      [CHANNELS-1:0]            run_out,
	output logic      [CHANNELS-1:0]            run_oe,
	output logic      [CHANNELS-1:0]            top_gate_drive,
	output logic      [CHANNELS-1:0]            bottom_gate_drive,
	output logic                                pwm_enable,
	output logic                                adc_valid,
	output logic                                nvm_access_en,
	output logic                                irq
);

	localparam int NA = $bits(ssfng_sup_type) + CHANNELS + 1;

	ssfng_state_type    state_r;
	ssfng_unl_type      unl_r;
	logic [NA-1:0]      meta_r;
	logic [NA-1:0]      sync_r;
	ssfng_sup_type      sup;
	logic [CHANNELS-1:0] pin_low;
	logic               share_s;
	logic               share_d_r;
	logic               vin_seen_r;
	logic               unlocked_r;
	logic               restart_need_r;
	logic               nvm_lock_r;
	logic [2:0]         ctrl_r;
	logic [13:0]        resp_r;
	logic [13:0]        pin_cfg_r;
	logic [15:0]        retry_r;
	logic [6:0]         addr_r;
	logic [5:0]         irq_sts_r;
	logic [5:0]         irq_en_r;
	logic [5:0]         irq_evt;
	logic [15:0]        peak_r;
	logic [15:0]        log_r;
	logic [8:0]         tb_cnt_r;
	logic [6:0]         sy_cnt_r;
	logic [5:0]         us_cnt_r;
	logic               us_tick;
	logic               init_ok;
	logic               released;
	logic               restricted;
	logic               restart_wr;
	logic               wr_en;
	logic               rd_setup;
	logic [CHANNELS-1:0] ch_off_r;
	logic [CHANNELS-1:0] shut_evt;
	logic [CHANNELS-1:0] ov_r;
	logic [CHANNELS-1:0][6:0] src;

	// Two-flop synchronisers; only sync_r is read downstream
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Pins and share line idle high, so no false fault or edge after reset
			meta_r <= {{$bits(ssfng_sup_type){1'b0}}, {(CHANNELS + 1){1'b1}}};
			sync_r <= {{$bits(ssfng_sup_type){1'b0}}, {(CHANNELS + 1){1'b1}}};
		end else if (clk_en) begin
			meta_r <= {supplies, fault_signal_pin_in, share_clk_in};
			sync_r <= meta_r;
		end
	end
	assign sup     = sync_r[NA-1 -: $bits(ssfng_sup_type)];
	assign pin_low = ~sync_r[CHANNELS:1];
	assign share_s = sync_r[0];

	assign init_ok  = sup.vin_uvlo_ok && sup.gate_driver_ok && sup.logic_3v3_ok && sup.ref_2v5_ok; // R1
	assign released = (state_r == ST_RUN);

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_LOCKOUT;
		end else if (clk_en) begin
			case (state_r)
				ST_LOCKOUT: if (init_ok) state_r <= ST_INIT; // R1
				ST_INIT: begin
					if (!init_ok) state_r <= ST_LOCKOUT;
					else if (sup.logic_3v3_fine) state_r <= ST_WAIT_ON; // R2
				end
				ST_WAIT_ON: begin
					if (!init_ok || !sup.logic_3v3_fine) state_r <= ST_LOCKOUT;
					else if (sup.vin_above_start) state_r <= ST_RUN; // R3
				end
				ST_RUN: begin
					if (!init_ok || !sup.logic_3v3_fine) state_r <= ST_LOCKOUT;
					else if (sup.vin_below_stop) state_r <= ST_WAIT_ON; // R4
				end
				default: state_r <= ST_LOCKOUT;
			endcase
		end
	end

	// Input supply history and restart gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vin_seen_r     <= 1'b0;
			restart_need_r <= 1'b0;
		end else if (clk_en) begin
			if (sup.vin_uvlo_ok) vin_seen_r <= 1'b1; // R6
			if (sup.vin_uvlo_ok && !vin_seen_r && unlocked_r) restart_need_r <= 1'b1; // R10
			else if (restart_wr) restart_need_r <= 1'b0; // R10
		end
	end

	// Bus target: restricted addressing and unlock detection
	assign restricted     = !vin_seen_r && !unlocked_r;
	assign pmb_addr_match = restricted ? (pmb_addr == `SSFNG_GLOBAL_A || pmb_addr == `SSFNG_GLOBAL_B) // R7
	                                   : (pmb_addr == addr_r || pmb_addr == `SSFNG_GLOBAL_B); // R5

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unl_r      <= UNL_IDLE;
			unlocked_r <= 1'b0;
		end else if (clk_en && pmb_wr.valid) begin
			case (unl_r)
				UNL_IDLE: begin
					if (pmb_wr.addr == `SSFNG_GLOBAL_B && pmb_wr.cmd == `SSFNG_UNLOCK_CMD &&
					    pmb_wr.data == `SSFNG_UNLOCK_D1) unl_r <= UNL_ARMED; // R8
				end
				UNL_ARMED: begin
					if (pmb_wr.addr == `SSFNG_GLOBAL_B && pmb_wr.cmd == `SSFNG_UNLOCK_CMD &&
					    pmb_wr.data == `SSFNG_UNLOCK_D2) begin
						unlocked_r <= 1'b1; // R8
						unl_r      <= UNL_IDLE;
					end else if (pmb_wr.addr == `SSFNG_GLOBAL_B && pmb_wr.cmd == `SSFNG_UNLOCK_CMD &&
					             pmb_wr.data == `SSFNG_UNLOCK_D1) begin
						unl_r <= UNL_ARMED; // R19
					end else begin
						unl_r <= UNL_IDLE; // R19
					end
				end
				default: unl_r <= UNL_IDLE;
			endcase
		end
	end

	// Thermal gate with hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvm_lock_r <= 1'b0;
		end else if (clk_en) begin
			if (sup.die_over_130) nvm_lock_r <= 1'b1; // R15
			else if (sup.die_below_120) nvm_lock_r <= 1'b0; // R15
		end
	end
	// Data stays in RAM; only the memory port is gated
	assign nvm_access_en = !nvm_lock_r && sup.logic_3v3_ok; // R15

	// Shared 1us prescaler for retry timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_cnt_r <= '0;
		end else if (clk_en) begin
			us_cnt_r <= us_tick ? 6'h00 : us_cnt_r + 6'h01;
		end
	end
	assign us_tick = (us_cnt_r == 6'(`SSFNG_US_CYC - 1));

	// Per-channel fault response
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic [15:0]   rcnt_r;
			logic          retry_r_f;
			logic [6:0]    stop;
			logic [1:0]    oe_hist_r;
			// Own pull-down still echoes through the synchroniser for two cycles
			assign src[g] = {pin_low[g] && !fault_signal_pin_oe[g] && !(|oe_hist_r), fault_evt[g]}; // R11
			always_comb begin
				for (int s = 0; s < 7; s++) begin
					stop[s] = src[g][s] && (ssfng_resp_type'(resp_r[2*s +: 2]) != RESP_IGNORE); // R12
				end
			end
			assign shut_evt[g] = |stop && !ch_off_r[g];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ch_off_r[g] <= 1'b0;
					retry_r_f   <= 1'b0;
					rcnt_r      <= '0;
				end else if (clk_en) begin
					if (shut_evt[g]) begin
						ch_off_r[g] <= 1'b1; // R12
						retry_r_f   <= ~|(stop & {7{1'b1}} & latch_mask(resp_r));
						rcnt_r      <= '0;
					end else if (ch_off_r[g] && restart_wr) begin
						ch_off_r[g] <= 1'b0;
					end else if (ch_off_r[g] && retry_r_f && us_tick) begin
						if (rcnt_r >= retry_r - 16'h0001) ch_off_r[g] <= 1'b0; // R12
						else rcnt_r <= rcnt_r + 16'h0001;
					end
				end
			end

			// Overvoltage overrides every setting
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ov_r[g] <= 1'b0;
				end else if (clk_en) begin
					ov_r[g] <= fault_evt[g][0]; // R13
				end
			end
			assign top_gate_drive[g]    = pwm_enable && !ch_off_r[g] && !ov_r[g]; // R13
			assign bottom_gate_drive[g] = ov_r[g]; // R13

			// Pin pulls low while a selected fault is active
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					fault_signal_pin_oe[g] <= 1'b0;
					oe_hist_r              <= 2'b00;
				end else if (clk_en) begin
					fault_signal_pin_oe[g] <= |(fault_evt[g] & pin_cfg_r[8*g +: 6]); // R11
					oe_hist_r              <= {oe_hist_r[0], fault_signal_pin_oe[g]};
				end
			end
			assign fault_signal_pin_out[g] = 1'b0;
			assign run_out[g] = 1'b0;
			assign run_oe[g]  = !released || ch_off_r[g]; // R2
		end
	endgenerate

	function automatic logic [6:0] latch_mask(input logic [13:0] r);
		logic [6:0] m;
		m = '0;
		for (int s = 0; s < 7; s++) m[s] = (r[2*s +: 2] == RESP_LATCH);
		return m;
	endfunction

	assign pwm_enable = released && vin_seen_r && !restart_need_r; // R10
	assign adc_valid  = vin_seen_r && !restart_need_r; // R10

	// Timebase line: realigns to any other driver's falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			share_d_r <= 1'b1;
			tb_cnt_r  <= '0;
		end else if (clk_en) begin
			share_d_r <= share_s;
			if (!released || (share_d_r && !share_s && tb_cnt_r > 9'(`SSFNG_TB_LOW_CYC)))
				tb_cnt_r <= 9'h001;
			else if (tb_cnt_r == 9'(`SSFNG_TB_PERIOD_CYC - 1))
				tb_cnt_r <= '0; // R18
			else
				tb_cnt_r <= tb_cnt_r + 9'h001;
		end
	end
	assign share_clk_out = 1'b0;
	assign share_clk_oe  = !released || (tb_cnt_r < 9'(`SSFNG_TB_LOW_CYC)); // R4 R18

	// Sync output pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy_cnt_r <= '0;
			sync_oe  <= 1'b0;
		end else if (clk_en) begin
			sy_cnt_r <= (sy_cnt_r == 7'(SYNC_PER - 1)) ? 7'h00 : sy_cnt_r + 7'h01;
			sync_oe  <= ctrl_r[`SSFNG_CTRL_SYNC_EN] && released &&
			            (sy_cnt_r < 7'(`SSFNG_SYNC_LOW_CYC)); // R17
		end
	end
	assign sync_out = 1'b0;

	// Peak header and fault log
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peak_r <= '0;
			log_r  <= '0;
		end else if (clk_en) begin
			if (meas_valid && meas_value > peak_r) peak_r <= meas_value; // R14
			if (ctrl_r[`SSFNG_CTRL_LOG_EN] && |shut_evt)
				log_r <= {1'b0, src[CHANNELS-1], 1'b0, src[0]}; // R14
		end
	end

	// APB slave, zero wait states
	assign wr_en      = psel && penable && pwrite;
	assign rd_setup   = psel && !penable && !pwrite;
	assign restart_wr = clk_en && wr_en && paddr == `SSFNG_OFF_CTRL && pwdata[`SSFNG_CTRL_RESTART];
	assign pready     = 1'b1;
	always_comb begin
		case (paddr)
			`SSFNG_OFF_CTRL, `SSFNG_OFF_STATUS, `SSFNG_OFF_FLT_RESP, `SSFNG_OFF_PIN_CFG,
			`SSFNG_OFF_RETRY, `SSFNG_OFF_IRQ_STS, `SSFNG_OFF_IRQ_CLR, `SSFNG_OFF_IRQ_EN,
			`SSFNG_OFF_LOG, `SSFNG_OFF_PEAK, `SSFNG_OFF_ADDR: pslverr = 1'b0;
			default: pslverr = psel && penable;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= '0;
			resp_r    <= `SSFNG_RST_FLT_RESP;
			pin_cfg_r <= '0;
			retry_r   <= `SSFNG_RST_RETRY;
			addr_r    <= `SSFNG_RST_ADDR;
			irq_en_r  <= '0;
		end else if (clk_en && wr_en) begin
			case (paddr)
				`SSFNG_OFF_CTRL:     ctrl_r    <= {pwdata[2], 1'b0, pwdata[0]};
				`SSFNG_OFF_FLT_RESP: resp_r    <= pwdata[13:0];
				`SSFNG_OFF_PIN_CFG:  pin_cfg_r <= pwdata[13:0];
				`SSFNG_OFF_RETRY:    retry_r   <= pwdata[15:0];
				`SSFNG_OFF_IRQ_EN:   irq_en_r  <= pwdata[5:0];
				`SSFNG_OFF_ADDR:     addr_r    <= pwdata[6:0];
				default: ;
			endcase
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	assign irq_evt = {unlocked_r == 1'b0 && pmb_wr.valid && unl_r == UNL_ARMED &&
	                  pmb_wr.data == `SSFNG_UNLOCK_D2 && pmb_wr.addr == `SSFNG_GLOBAL_B &&
	                  pmb_wr.cmd == `SSFNG_UNLOCK_CMD,
	                  sup.die_over_130 && !nvm_lock_r,
	                  released && sup.vin_below_stop,
	                  |ov_r,
	                  shut_evt[1], shut_evt[0]};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sts_r <= '0;
		end else if (clk_en) begin
			irq_sts_r <= (irq_sts_r & ~((wr_en && paddr == `SSFNG_OFF_IRQ_CLR) ? pwdata[5:0] : 6'h00)) | irq_evt;
		end
	end
	assign irq = |(irq_sts_r & irq_en_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (clk_en && rd_setup) begin
			case (paddr)
				`SSFNG_OFF_CTRL:     prdata <= {29'h0, ctrl_r};
				`SSFNG_OFF_STATUS:   prdata <= {24'h0, nvm_lock_r, adc_valid, pwm_enable, 1'b0, vin_seen_r, // R6
				                                nvm_access_en, released, unlocked_r};
				`SSFNG_OFF_FLT_RESP: prdata <= {18'h0, resp_r};
				`SSFNG_OFF_PIN_CFG:  prdata <= {18'h0, pin_cfg_r};
				`SSFNG_OFF_RETRY:    prdata <= {16'h0, retry_r};
				`SSFNG_OFF_IRQ_STS:  prdata <= {26'h0, irq_sts_r};
				`SSFNG_OFF_IRQ_EN:   prdata <= {26'h0, irq_en_r};
				`SSFNG_OFF_LOG:      prdata <= {8'h0, 6'h0, ch_off_r, log_r};
				`SSFNG_OFF_PEAK:     prdata <= {16'h0, peak_r}; // R14
				`SSFNG_OFF_ADDR:     prdata <= {25'h0, addr_r};
				default:             prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Checks
	a_hold_before_fine: assert property (@(posedge pclk) disable iff (!presetn) // R2
		!sup.logic_3v3_fine |=> run_oe == {CHANNELS{1'b1}} && share_clk_oe) else $error("lines released early");
	a_lockout_init: assert property (@(posedge pclk) disable iff (!presetn) // R1
		!init_ok |=> state_r == ST_LOCKOUT) else $error("left lockout without supplies");
	a_start_thresh: assert property (@(posedge pclk) disable iff (!presetn) // R3
		$rose(released) |-> $past(sup.vin_above_start)) else $error("started below start threshold");
	a_stop_pull: assert property (@(posedge pclk) disable iff (!presetn) // R4
		released && sup.vin_below_stop && clk_en |=> share_clk_oe && !released) else $error("stop not honoured");
	a_nvm_flag: assert property (@(posedge pclk) disable iff (!presetn) // R6
		rd_setup && clk_en && paddr == `SSFNG_OFF_STATUS && !vin_seen_r |=> !prdata[3]) else $error("bit 3 wrong");
	a_addr_restrict: assert property (@(posedge pclk) disable iff (!presetn) // R7
		restricted && pmb_addr_match |-> pmb_addr inside {7'h5A, 7'h5B}) else $error("wrong address answered");
	a_ov_gate: assert property (@(posedge pclk) disable iff (!presetn) // R13
		clk_en && fault_evt[0][0] |=> !top_gate_drive[0] && bottom_gate_drive[0]) else $error("ov not forced");
	a_thermal_gate: assert property (@(posedge pclk) disable iff (!presetn) // R15
		nvm_lock_r && !sup.die_below_120 |=> !nvm_access_en) else $error("memory access while hot");
	a_restart_gate: assert property (@(posedge pclk) disable iff (!presetn) // R10
		restart_need_r |-> !pwm_enable && !adc_valid) else $error("pwm before restart");
	a_tb_low_time: assert property (@(posedge pclk) disable iff (!presetn || !released) // R18
		$rose(share_clk_oe) |-> ##38 share_clk_oe ##2 !share_clk_oe) else $error("timebase low width wrong");
	a_sync_width: assert property (@(posedge pclk) disable iff (!presetn) // R17
		sync_oe |-> sy_cnt_r <= 7'(`SSFNG_SYNC_LOW_CYC)) else $error("sync pulse too long");

	c_unlock: cover property (@(posedge pclk) disable iff (!presetn) $rose(unlocked_r));
	c_retry: cover property (@(posedge pclk) disable iff (!presetn) $fell(ch_off_r[0]));
	c_run: cover property (@(posedge pclk) disable iff (!presetn) $rose(released));

endmodule

//--- core/ssfng_pkg.sv
// Types shared by the supervisor core and its bench
// Assumes ssfng_consts.svh is on the include path
`include "ssfng_consts.svh"
package ssfng_pkg;

	typedef enum logic [2:0] {
		ST_LOCKOUT = 3'b000,
		ST_INIT    = 3'b001,
		ST_WAIT_ON = 3'b010,
		ST_RUN     = 3'b011
	} ssfng_state_type;

	typedef enum logic [1:0] {
		RESP_IGNORE = 2'b00,
		RESP_LATCH  = 2'b01,
		RESP_RETRY  = 2'b10
	} ssfng_resp_type;

	typedef enum logic [0:0] {
		UNL_IDLE  = 1'b0,
		UNL_ARMED = 1'b1
	} ssfng_unl_type;

	// Comparator levels, all asynchronous to pclk
	typedef struct packed {
		logic vin_uvlo_ok;
		logic gate_driver_ok;
		logic logic_3v3_ok;
		logic ref_2v5_ok;
		logic logic_3v3_fine;
		logic vin_above_start;
		logic vin_below_stop;
		logic die_over_130;
		logic die_below_120;
	} ssfng_sup_type;

	// One write seen by the bus target
	typedef struct packed {
		logic       valid;
		logic [6:0] addr;
		logic [7:0] cmd;
		logic [7:0] data;
	} ssfng_pmb_wr_type;

endpackage

//--- testbench/ssfng_host_model.sv
// Host side: bus-target write pulses, fault pin and share line pull-ups
// Assumes it shares pclk with the supervisor core
`timescale 1ns/10ps
module ssfng_host_model
	import ssfng_pkg::*;
(
	input  wire logic       pclk,
	output ssfng_pmb_wr_type pmb_wr,
	input  wire logic [1:0] pin_oe,
	output logic      [1:0] pin_in,
	input  wire logic       share_oe,
	output logic            share_in
);
	logic [1:0] ext_low_r;
	initial begin
		pmb_wr = '0;
		ext_low_r = 2'h0;
	end
	// Pulled-up lines read high once released
	assign pin_in = ~(pin_oe | ext_low_r);
	assign share_in = ~share_oe;
	// Never stores to memory, so no hot writes and no save step
	// Back-to-back calls give consecutive pulses
	task automatic put(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
		@(posedge pclk);
		pmb_wr <= {1'b1, a, c, d};
	endtask
	task automatic idle();
		@(posedge pclk);
		pmb_wr <= '0;
	endtask
	task automatic pull(input logic [1:0] v);
		@(posedge pclk);
		ext_low_r <= v;
	endtask
endmodule

//--- testbench/tb_ssfng_core.sv
// Bench for the supervisor core: APB master, supplies, faults
// Assumes the host model drives bus-target writes and pin levels
`timescale 1ns/10ps
module tb_ssfng_core
	import ssfng_pkg::*;
;
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv_v;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd_v;
	ssfng_sup_type    sup;
	ssfng_pmb_wr_type pmb_wr;
	logic [6:0]       pmb_addr;
	logic             match, sh_oe, sh_in, sync_oe, pwm, nvm, adc, mv;
	logic [15:0]      md;
	logic [1:0][5:0]  fe;
	logic [1:0]       pin_in, pin_oe, run_oe, tg, bg;
	int               mismatches, compares, cyc, n, p;

	ssfng_core DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .supplies(sup), .pmb_wr(pmb_wr), .pmb_addr(pmb_addr), .pmb_addr_match(match),
		.fault_evt(fe), .meas_valid(mv), .meas_value(md), .fault_signal_pin_in(pin_in),
		.fault_signal_pin_out(), .fault_signal_pin_oe(pin_oe), .share_clk_in(sh_in), .share_clk_out(),
		.share_clk_oe(sh_oe), .sync_out(), .sync_oe(sync_oe), .run_out(), .run_oe(run_oe),
		.top_gate_drive(tg), .bottom_gate_drive(bg), .pwm_enable(pwm), .adc_valid(adc),
		.nvm_access_en(nvm), .irq(irq));
	ssfng_host_model host (.pclk(pclk), .pmb_wr(pmb_wr), .pin_oe(pin_oe), .pin_in(pin_in),
		.share_oe(sh_oe), .share_in(sh_in));

	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic w(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_v = prdata;
		slv_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Low time and period of a pull-down, skipping a partial pulse
	task automatic len(input bit s, output int k, output int q);
		k = 0;
		while ((s ? sync_oe : sh_oe) === 1'b1) w(1);
		while ((s ? sync_oe : sh_oe) !== 1'b1) w(1);
		while ((s ? sync_oe : sh_oe) === 1'b1) begin
			k++;
			w(1);
		end
		q = k;
		while ((s ? sync_oe : sh_oe) !== 1'b1) begin
			q++;
			w(1);
		end
	endtask

	task automatic t_lock();
		w(4);
		chk("run_oe", 3, run_oe);
		chk("share_oe", 1, sh_oe);
		chk("top_gate", 0, tg);
		apb(0, 12'h004, 32'h0);
		chk("nvm_init", 0, rd_v[3]);
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			pmb_addr <= (i == 2) ? 7'h40 : 7'h5A + 7'(i);
			w(1);
			chk("match", 32'(i != 2), match);
		end
	endtask
	task automatic t_unlock();
		apb(1, 12'h01C, 32'h20);
		host.put(7'h5B, 8'hBD, 8'h2B);
		host.put(7'h5B, 8'h01, 8'h00);
		host.put(7'h5B, 8'hBD, 8'hC4);
		host.idle();
		w(2);
		chk("match", 0, match);
		host.put(7'h5B, 8'hBD, 8'h2B);
		host.put(7'h5B, 8'hBD, 8'hC4);
		host.idle();
		w(2);
		chk("match", 1, match);
		chk("irq", 1, irq);
		apb(1, 12'h018, 32'h20);
		w(2);
		chk("irq", 0, irq);
	endtask
	task automatic t_power();
		@(posedge pclk);
		sup.vin_uvlo_ok <= 1'b1;
		sup.gate_driver_ok <= 1'b1;
		w(8);
		chk("run_oe", 3, run_oe);
		@(posedge pclk);
		sup.vin_above_start <= 1'b1;
		w(8);
		chk("run_oe", 0, run_oe);
		chk("pwm", 0, pwm);
		chk("adc", 0, adc);
		apb(1, 12'h000, 32'h7);
		w(3);
		chk("pwm", 1, pwm);
		chk("adc", 1, adc);
		len(0, n, p);
		chk("share_low", 40, n);
		chk("share_per", 400, p);
		len(1, n, p);
		chk("sync_low", 20, n);
	endtask
	task automatic t_stop();
		@(posedge pclk);
		sup.vin_above_start <= 1'b0;
		sup.vin_below_stop <= 1'b1;
		w(8);
		@(posedge pclk);
		sup.vin_below_stop <= 1'b0;
		n = 0;
		// A whole timebase period, so a free-running line would show
		repeat (450) begin
			w(1);
			n += (sh_oe === 1'b1);
		end
		chk("share_held", 450, n);
		@(posedge pclk);
		sup.vin_above_start <= 1'b1;
		w(8);
		chk("run_oe", 0, run_oe);
	endtask
	task automatic t_fault();
		apb(1, 12'h008, 32'h2001);
		// Two microseconds, so the retry lands well clear of the checks
		apb(1, 12'h010, 32'h2);
		apb(1, 12'h00C, 32'h1);
		apb(0, 12'h040, 32'h0);
		chk("slverr", 1, slv_v);
		@(posedge pclk);
		fe[0][0] <= 1'b1;
		w(3);
		chk("top_gate", 0, tg[0]);
		chk("bot_gate", 1, bg[0]);
		chk("pin_oe", 1, pin_oe[0]);
		@(posedge pclk);
		fe[0][0] <= 1'b0;
		w(100);
		chk("latched", 1, run_oe[0]);
		chk("pin_oe", 0, pin_oe[0]);
		apb(0, 12'h020, 32'h0);
		chk("log", 32'h0001_0001, rd_v);
		@(posedge pclk);
		mv <= 1'b1;
		md <= 16'h1234;
		@(posedge pclk);
		mv <= 1'b0;
		apb(0, 12'h024, 32'h0);
		chk("peak", 32'h0000_1234, rd_v);
		apb(1, 12'h000, 32'h2);
		w(4);
		chk("run_oe", 0, run_oe[0]);
		host.pull(2'h2);
		w(4);
		host.pull(2'h0);
		w(2);
		chk("pin_fault", 1, run_oe[1]);
		w(90);
		chk("retried", 0, run_oe[1]);
	endtask
	task automatic t_therm();
		@(posedge pclk);
		sup.die_over_130 <= 1'b1;
		sup.die_below_120 <= 1'b0;
		w(6);
		chk("nvm", 0, nvm);
		@(posedge pclk);
		sup.die_over_130 <= 1'b0;
		w(6);
		chk("nvm", 0, nvm);
		@(posedge pclk);
		sup.die_below_120 <= 1'b1;
		w(6);
		chk("nvm", 1, nvm);
		@(posedge pclk);
		sup.logic_3v3_fine <= 1'b0;
		w(6);
		chk("run_oe", 3, run_oe);
		chk("share_oe", 1, sh_oe);
	endtask

	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Ceiling well above the longest sequence
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sup = '0;
		sup.logic_3v3_ok = 1'b1;
		sup.ref_2v5_ok = 1'b1;
		sup.logic_3v3_fine = 1'b1;
		sup.die_below_120 = 1'b1;
		pmb_addr = 7'h40;
		fe = '0;
		{mv, md} = '0;
		{mismatches, compares, cyc} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_lock();
		t_unlock();
		t_power();
		t_stop();
		t_fault();
		t_therm();
		report_and_stop();
	end
endmodule
